// >>> rtl/rdio_pkg.sv
// Constants for the dedicated remote-operation I/O handler.
// Assumes a single 20 MHz clock domain; no timescale in packages.
package rdio_pkg;
	localparam int RDIO_CLK_HZ = 20000000;
	localparam int RDIO_SLOTS = 32;
	localparam int RDIO_IO_W = 8;
	localparam int RDIO_NUM_W = 16;
	localparam int RDIO_SIG_W = 8;
	localparam int RDIO_GPO_W = 32;
	// Power-on settle time in microseconds and its cycle count
	localparam int RDIO_PON_US = 100;
	localparam int RDIO_PON_CYC = (RDIO_PON_US * (RDIO_CLK_HZ / 1000000));
	// Fixed input number of the global stop
	localparam logic [7:0] RDIO_STOP_SIGNO = 8'h00;
	// Register byte addresses
	localparam logic [7:0] RDIO_A_STATUS = 8'h00;
	localparam logic [7:0] RDIO_A_PROG = 8'h04;
	localparam logic [7:0] RDIO_A_OVRD = 8'h08;
	localparam logic [7:0] RDIO_A_EVENT = 8'h0c;
	localparam logic [7:0] RDIO_A_RUN = 8'h10;
	localparam logic [7:0] RDIO_A_GPO = 8'h14;
	localparam logic [7:0] RDIO_A_MAP = 8'h18;
	// Event register bit positions (a written one sets the error or ends run, cycle stop or evasion; EMG bit unused)
	localparam int RDIO_EV_ERR = 0;
	localparam int RDIO_EV_EMG = 1;
	localparam int RDIO_EV_DONE = 2;
	localparam int RDIO_EV_CYCDONE = 3;
	localparam int RDIO_EV_EVADONE = 4;
	localparam logic [15:0] RDIO_OVRD_RST = 16'h0064;
	typedef enum logic [1:0] {
		RDIO_MD_TEACH = 2'b00,
		RDIO_MD_PANEL = 2'b01,
		RDIO_MD_REMOTE = 2'b10
	} rdio_mode_t;
endpackage

// >>> rtl/rdio_handler.sv
// Dedicated remote-operation input/output handler of a robot controller.
// Assumes request pins synchronous to i_clk; controller firmware on Avalon-MM.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module rdio_handler
	import rdio_pkg::*;
#(
	parameter int PON_CYC = rdio_pkg::RDIO_PON_CYC
) (
	input wire logic i_clk, // Controller clock
	input wire logic i_rst_b, // Async reset, active low
	input wire rdio_pkg::rdio_mode_t i_mode, // Mode key position
	input wire logic i_auto_run_permit, // Level
	input wire logic i_start_req, // Edge
	input wire logic i_stop_in, // Level, input number 0
	input wire logic i_program_reset_req, // Edge
	input wire logic i_fault_clear_req, // Edge
	input wire logic i_cycle_stop_req, // Edge
	input wire logic i_drive_off_req, // Level
	input wire logic i_drive_on_req, // Edge
	input wire logic i_operation_rights_req, // Level
	input wire logic i_motion_lock_toggle, // Edge
	input wire logic i_evasion_return_req, // Edge
	input wire logic i_gp_output_clear_req, // Edge
	input wire logic i_emergency_stop_in, // Emergency stop level
	input wire logic [31:0] i_slot_run_req, // Per-slot start edges
	input wire logic [31:0] i_slot_halt_in, // Per-slot stop levels
	input wire logic i_program_select_req, // Edge
	input wire logic i_override_select_req, // Edge
	input wire logic [15:0] i_numeric_value_field, // Numeric value inputs
	input wire logic [7:0] avs_address, // Avalon byte address
	input wire logic avs_read, // Avalon read
	input wire logic avs_write, // Avalon write
	input wire logic [31:0] avs_writedata, // Avalon write data
	output logic [31:0] avs_readdata, // Avalon read data
	output logic avs_waitrequest, // Avalon wait
	output logic o_teach_mode_flag, // Teaching mode
	output logic o_panel_auto_mode_flag, // Automatic from panel
	output logic o_remote_mode_flag, // Remote mode
	output logic o_power_on_complete, // Inputs accepted
	output logic o_auto_enabled, // Auto operation enabled
	output logic o_operating, // Any slot running
	output logic o_waiting, // Any slot temporarily stopped
	output logic o_prog_sel_enabled, // Program selection allowed
	output logic o_error, // Error present
	output logic o_in_cycle_stop, // Cycle stop in progress
	output logic o_drive_off_echo, // Servo-on disabled echo
	output logic o_servo_on, // Servo on
	output logic o_operation_rights, // External rights valid
	output logic o_motion_lock, // Machine lock state
	output logic o_evasion_active, // Evasion return in progress
	output logic o_emergency_stop_flag, // Emergency stop occurred
	output logic [31:0] o_slot_operating, // Per-slot operating
	output logic [31:0] o_slot_waiting, // Per-slot wait
	output logic [31:0] o_gp_out, // General-purpose outputs
	output logic [15:0] o_program_no, // Selected program
	output logic [15:0] o_override // Selected override
);
	localparam int PCW = $clog2(PON_CYC + 1);
	localparam logic [PCW-1:0] PON_LAST = PCW'(PON_CYC);

	// Edge-class request history
	logic [11:0] edg_q, edg_d;
	logic [31:0] sedg_q, sedg_d;
	logic [11:0] edg_in, edg_rise;
	logic [31:0] srise;
	logic [PCW-1:0] pon_q, pon_d;
	logic rdy_q, rdy_d;
	logic [31:0] run_q, run_d, wait_q, wait_d, gpo_q, gpo_d;
	logic err_q, err_d, emg_q, emg_d, cyc_q, cyc_d, srv_q, srv_d;
	logic lock_q, lock_d, eva_q, eva_d, psel_q, psel_d;
	logic [15:0] prog_q, prog_d, ovrd_q, ovrd_d;
	logic [31:0] rdat_q, rdat_d;
	logic ack_q, ack_d;
	logic [7:0] map_q, map_d;
	logic remote, rights, permit, halt_all;
	logic [31:0] halt_vec;

	assign edg_in = {i_override_select_req, i_program_select_req, i_gp_output_clear_req,
		i_evasion_return_req, i_motion_lock_toggle, i_drive_on_req, i_cycle_stop_req,
		i_fault_clear_req, i_program_reset_req, i_start_req, 2'b00};
	assign edg_rise = edg_in & ~edg_q;
	assign srise = i_slot_run_req & ~sedg_q;

	assign remote = (i_mode == RDIO_MD_REMOTE);
	assign rights = rdy_q & remote & i_operation_rights_req;
	assign permit = rights & i_auto_run_permit;
	assign halt_all = i_stop_in | emg_q;
	assign halt_vec = i_slot_halt_in | {32{halt_all}};

	always_comb begin
		edg_d = edg_in;
		sedg_d = i_slot_run_req;
		pon_d = pon_q;
		rdy_d = rdy_q;
		if (pon_q != PON_LAST) begin
			pon_d = pon_q + PCW'(1);
		end else begin
			rdy_d = 1'b1;
		end
		run_d = run_q;
		wait_d = wait_q;
		err_d = err_q;
		emg_d = i_emergency_stop_in;
		cyc_d = cyc_q;
		srv_d = srv_q;
		lock_d = lock_q;
		eva_d = eva_q;
		gpo_d = gpo_q;
		prog_d = prog_q;
		ovrd_d = ovrd_q;
		map_d = map_q;
		rdat_d = rdat_q;
		ack_d = 1'b0;
		if (i_drive_off_req | emg_q) begin
			srv_d = 1'b0;
		end else if (rights & edg_rise[6]) begin
			srv_d = 1'b1;
		end
		if (rights) begin
			if (edg_rise[7]) begin
				lock_d = ~lock_q;
			end
			if (edg_rise[5] & (|run_q)) begin
				cyc_d = 1'b1;
			end
			if (edg_rise[8] & srv_q & ~(|run_q)) begin
				eva_d = 1'b1;
			end
			if (edg_rise[9]) begin
				gpo_d = '0;
			end
			if (edg_rise[10] & psel_q) begin
				prog_d = i_numeric_value_field;
			end
			if (edg_rise[11]) begin
				ovrd_d = i_numeric_value_field;
			end
			if (edg_rise[3]) begin
				wait_d = wait_q & halt_vec;
				run_d = run_q & ~wait_q;
			end
			if (permit & srv_q & ~err_q) begin
				run_d = run_d | ((srise | {32{edg_rise[2]}}) & ~halt_vec);
				wait_d = wait_d & ~((srise | {32{edg_rise[2]}}) & ~halt_vec);
			end
		end
		wait_d = wait_d | (run_d & halt_vec);
		run_d = run_d & ~halt_vec;
		if (i_emergency_stop_in) begin
			err_d = 1'b1;
		end else if (edg_rise[4]) begin
			err_d = 1'b0;
		end
		// Avalon slave: one-cycle wait, then answer
		if ((avs_read | avs_write) & ~ack_q) begin
			ack_d = 1'b1;
			rdat_d = '0;
			unique case (avs_address)
				RDIO_A_STATUS: rdat_d = {16'h0000, 3'b000, psel_q, eva_q, lock_q, srv_q, cyc_q,
					err_q, emg_q, rdy_q, permit, rights, 1'b0, i_mode};
				RDIO_A_PROG: rdat_d = {16'h0000, prog_q};
				RDIO_A_OVRD: rdat_d = {16'h0000, ovrd_q};
				RDIO_A_RUN: rdat_d = run_q;
				RDIO_A_GPO: rdat_d = gpo_q;
				RDIO_A_MAP: rdat_d = {24'h000000, map_q};
				default: rdat_d = '0;
			endcase
			if (avs_write) begin
				rdat_d = '0;
				unique case (avs_address)
					RDIO_A_GPO: gpo_d = avs_writedata;
					RDIO_A_MAP: map_d = avs_writedata[7:0];
					RDIO_A_EVENT: begin
						if (avs_writedata[RDIO_EV_ERR]) begin
							err_d = 1'b1;
						end
						if (avs_writedata[RDIO_EV_DONE]) begin
							run_d = '0;
						end
						if (avs_writedata[RDIO_EV_CYCDONE]) begin
							cyc_d = 1'b0;
							run_d = '0;
						end
						if (avs_writedata[RDIO_EV_EVADONE]) begin
							eva_d = 1'b0;
						end
					end
					default: ;
				endcase
			end
		end
		if (~(|run_d)) begin
			cyc_d = 1'b0;
		end
		if (~srv_d) begin
			eva_d = 1'b0;
		end
		psel_d = ~(|run_d) & ~(|wait_d) & ~err_d;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			edg_q <= '0;
			sedg_q <= '0;
			pon_q <= '0;
			rdy_q <= 1'b0;
			run_q <= '0;
			wait_q <= '0;
			err_q <= 1'b0;
			emg_q <= 1'b0;
			cyc_q <= 1'b0;
			srv_q <= 1'b0;
			lock_q <= 1'b0;
			eva_q <= 1'b0;
			psel_q <= 1'b0;
			gpo_q <= '0;
			prog_q <= '0;
			ovrd_q <= RDIO_OVRD_RST;
			map_q <= RDIO_STOP_SIGNO;
			rdat_q <= '0;
			ack_q <= 1'b0;
		end else begin
			edg_q <= edg_d;
			sedg_q <= sedg_d;
			pon_q <= pon_d;
			rdy_q <= rdy_d;
			run_q <= run_d;
			wait_q <= wait_d;
			err_q <= err_d;
			emg_q <= emg_d;
			cyc_q <= cyc_d;
			srv_q <= srv_d;
			lock_q <= lock_d;
			eva_q <= eva_d;
			psel_q <= psel_d;
			gpo_q <= gpo_d;
			prog_q <= prog_d;
			ovrd_q <= ovrd_d;
			map_q <= map_d;
			rdat_q <= rdat_d;
			ack_q <= ack_d;
		end
	end

	// Status outputs, registered copies of state, of the mode and drive-off inputs, and of rights and run permit gated by ready and remote mode
	logic [17:0] st_q;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= {i_mode == RDIO_MD_TEACH, i_mode == RDIO_MD_PANEL, remote, rdy_q, permit,
				|run_q, |wait_q, psel_q, err_q, cyc_q, i_drive_off_req, srv_q, rights,
				lock_q, eva_q, emg_q, 2'b00};
		end
	end

	assign o_teach_mode_flag = st_q[17];
	assign o_panel_auto_mode_flag = st_q[16];
	assign o_remote_mode_flag = st_q[15];
	assign o_power_on_complete = st_q[14];
	assign o_auto_enabled = st_q[13];
	assign o_operating = st_q[12];
	assign o_waiting = st_q[11];
	assign o_prog_sel_enabled = st_q[10];
	assign o_error = st_q[9];
	assign o_in_cycle_stop = st_q[8];
	assign o_drive_off_echo = st_q[7];
	assign o_servo_on = st_q[6];
	assign o_operation_rights = st_q[5];
	assign o_motion_lock = st_q[4];
	assign o_evasion_active = st_q[3];
	assign o_emergency_stop_flag = st_q[2];
	assign o_slot_operating = run_q;
	assign o_slot_waiting = wait_q;
	assign o_gp_out = gpo_q;
	assign o_program_no = prog_q;
	assign o_override = ovrd_q;
	assign avs_readdata = rdat_q;
	assign avs_waitrequest = ~ack_q;

	chk_mode_onehot: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(i_rst_b) |-> $onehot({o_teach_mode_flag, o_panel_auto_mode_flag,
		o_remote_mode_flag})) else $error("mode outputs not one-hot");
	chk_ready_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!rdy_q |-> run_q == '0) else $error("slot ran before ready");
	chk_stop_halt: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_stop_in |=> run_q == '0) else $error("stop did not halt");
	chk_err_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_fault_clear_req && !edg_q[4] && !i_emergency_stop_in && !avs_write) |=> !err_q)
		else $error("error not cleared");
	chk_drive_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_drive_off_req |=> !srv_q ##1 o_drive_off_echo == $past(i_drive_off_req))
		else $error("drive off not honoured");
	chk_servo_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(rights && edg_rise[6] && !i_drive_off_req && !emg_q) |=> srv_q)
		else $error("servo not switched on");
	chk_lock_tog: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(rights && edg_rise[7]) |=> lock_q != $past(lock_q)) else $error("lock not toggled");
	chk_eva_start: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(rights && edg_rise[8] && srv_q && run_q == '0 && !i_drive_off_req && !emg_q
		&& !avs_write) |=> eva_q) else $error("evasion return not started");
	chk_gpo_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(rights && edg_rise[9] && !avs_write) |=> gpo_q == '0)
		else $error("outputs not cleared");
	chk_ovrd_take: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(rights && edg_rise[11]) |=> ovrd_q == $past(i_numeric_value_field))
		else $error("override not taken");
	sequence s_bus_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	chk_bus_ans: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		s_bus_req ##0 !ack_q |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer late");
	chk_emg_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_emergency_stop_in ##1 i_emergency_stop_in |=> o_emergency_stop_flag && err_q)
		else $error("emergency not flagged");
endmodule

// >>> bench/rdio_plc_model.sv
// Far-side model of the external logic controller driving request pins.
// Assumes the handler samples every request on the rising edge of i_clk.
`timescale 1ns/1ps
module rdio_plc_model (
	input wire logic i_clk, // Controller clock
	output logic [9:0] o_edge_req, // Edge-class requests
	output logic [31:0] o_slot_run_req, // Per-slot start edges
	output logic o_emergency_stop_in, // Emergency stop level
	output logic o_operation_rights_req // Rights request level
);
	initial begin
		o_edge_req = '0;
		o_slot_run_req = '0;
		o_emergency_stop_in = 1'b0;
		o_operation_rights_req = 1'b1;
	end
	task automatic pulse(input int idx);
		@(posedge i_clk);
		o_edge_req[idx] <= 1'b1;
		@(posedge i_clk);
		o_edge_req[idx] <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic slot_pulse(input int n);
		@(posedge i_clk);
		o_slot_run_req[n] <= 1'b1;
		@(posedge i_clk);
		o_slot_run_req[n] <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic emergency(input logic on);
		@(posedge i_clk);
		o_emergency_stop_in <= on;
	endtask
	task automatic rights(input logic on);
		@(posedge i_clk);
		o_operation_rights_req <= on;
	endtask
endmodule

// >>> bench/rdio_handler_tb.sv
// Self-checking bench for the dedicated remote-operation I/O handler.
// Assumes the far-side model drives edges, rights and emergency stop.
`timescale 1ns/1ps
module rdio_handler_tb;
	import rdio_pkg::*;
	localparam int PON = 4;
	localparam int E_START = 0, E_PRST = 1, E_FCLR = 2, E_CYC = 3, E_DON = 4, E_LOCK = 5;
	localparam int E_EVA = 6, E_GCLR = 7, E_PSEL = 8, E_OSEL = 9;
	logic i_clk, i_rst_b, i_auto_run_permit, i_stop_in, i_drive_off_req;
	logic avs_read, avs_write, avs_waitrequest, emg, rights;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, i_slot_halt_in, rdata, srun;
	logic [31:0] o_slot_operating, o_slot_waiting, o_gp_out;
	logic [15:0] i_numeric_value_field, o_program_no, o_override;
	logic [9:0] ev;
	rdio_mode_t i_mode;
	logic o_teach_mode_flag, o_panel_auto_mode_flag, o_remote_mode_flag, o_power_on_complete;
	logic o_auto_enabled, o_operating, o_waiting, o_prog_sel_enabled, o_error;
	logic o_in_cycle_stop, o_drive_off_echo, o_servo_on, o_operation_rights;
	logic o_motion_lock, o_evasion_active, o_emergency_stop_flag;
	rdio_mode_t mds[3] = '{RDIO_MD_TEACH, RDIO_MD_PANEL, RDIO_MD_REMOTE};
	logic [2:0] oh[3] = '{3'b100, 3'b010, 3'b001};
	int bad_count, tests_run, cyc;
	rdio_plc_model i_plc (.i_clk, .o_edge_req(ev), .o_slot_run_req(srun),
		.o_emergency_stop_in(emg), .o_operation_rights_req(rights));
	rdio_handler #(.PON_CYC(PON)) i_dut (
		.i_clk, .i_rst_b, .i_mode, .i_auto_run_permit, .i_start_req(ev[E_START]),
		.i_stop_in, .i_program_reset_req(ev[E_PRST]), .i_fault_clear_req(ev[E_FCLR]),
		.i_cycle_stop_req(ev[E_CYC]), .i_drive_off_req, .i_drive_on_req(ev[E_DON]),
		.i_operation_rights_req(rights), .i_motion_lock_toggle(ev[E_LOCK]),
		.i_evasion_return_req(ev[E_EVA]), .i_gp_output_clear_req(ev[E_GCLR]),
		.i_emergency_stop_in(emg), .i_slot_run_req(srun), .i_slot_halt_in,
		.i_program_select_req(ev[E_PSEL]), .i_override_select_req(ev[E_OSEL]),
		.i_numeric_value_field, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .o_teach_mode_flag, .o_panel_auto_mode_flag,
		.o_remote_mode_flag, .o_power_on_complete, .o_auto_enabled, .o_operating,
		.o_waiting, .o_prog_sel_enabled, .o_error, .o_in_cycle_stop, .o_drive_off_echo,
		.o_servo_on, .o_operation_rights, .o_motion_lock, .o_evasion_active,
		.o_emergency_stop_flag, .o_slot_operating, .o_slot_waiting, .o_gp_out,
		.o_program_no, .o_override);
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic pl(input int i);
		i_plc.pulse(i);
		w(3);
	endtask
	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		do begin
			@(posedge i_clk);
		end while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask
	task automatic done(input string s);
		$display("Finished %s", s);
	endtask
	initial begin
		i_rst_b = 1'b0;
		i_auto_run_permit = 1'b0;
		i_stop_in = 1'b0;
		i_drive_off_req = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h00000000;
		i_slot_halt_in = 32'h00000000;
		i_numeric_value_field = 16'h0000;
		i_mode = RDIO_MD_REMOTE;
		cyc = 0;
		repeat (16) @(posedge i_clk);
		chk(o_power_on_complete, 1'b0);
		chk(o_override, RDIO_OVRD_RST);
		i_rst_b <= 1'b1;
		pl(E_DON);
		w(PON + 6);
		chk(o_power_on_complete, 1'b1);
		chk(o_servo_on, 1'b0);
		done("reset");
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk);
			i_mode <= mds[k];
			w(3);
			chk({o_teach_mode_flag, o_panel_auto_mode_flag, o_remote_mode_flag}, oh[k]);
		end
		i_plc.rights(1'b0);
		w(3);
		chk(o_operation_rights, 1'b0);
		pl(E_LOCK);
		chk(o_motion_lock, 1'b0);
		i_plc.rights(1'b1);
		w(3);
		chk(o_operation_rights, 1'b1);
		for (int k = 0; k < 2; k++) begin
			pl(E_LOCK);
			chk(o_motion_lock, 32'(k == 0));
		end
		rdc(RDIO_A_MAP, 32'h0);
		bus(1'b1, RDIO_A_MAP, 32'h5);
		rdc(RDIO_A_MAP, 32'h5);
		rdc(8'h1c, 32'h0);
		done("mode and map");
		@(posedge i_clk);
		i_auto_run_permit <= 1'b1;
		i_drive_off_req <= 1'b1;
		w(3);
		chk(o_auto_enabled, 1'b1);
		chk(o_drive_off_echo, 1'b1);
		i_drive_off_req <= 1'b0;
		w(3);
		chk(o_drive_off_echo, 1'b0);
		pl(E_DON);
		chk(o_servo_on, 1'b1);
		i_auto_run_permit <= 1'b0;
		pl(E_START);
		chk(o_auto_enabled, 1'b0);
		chk(o_operating, 1'b0);
		i_auto_run_permit <= 1'b1;
		pl(E_START);
		chk(o_operating, 1'b1);
		chk(o_slot_operating, 32'hffffffff);
		pl(E_CYC);
		chk(o_in_cycle_stop, 1'b1);
		bus(1'b1, RDIO_A_EVENT, 32'h8);
		w(3);
		chk(o_in_cycle_stop, 1'b0);
		chk(o_operating, 1'b0);
		pl(E_START);
		i_stop_in <= 1'b1;
		w(3);
		chk(o_waiting, 1'b1);
		chk(o_slot_waiting, 32'hffffffff);
		i_stop_in <= 1'b0;
		pl(E_PRST);
		chk(o_waiting, 1'b0);
		chk(o_prog_sel_enabled, 1'b1);
		done("run and stop");
		i_numeric_value_field <= 16'h0123;
		pl(E_PSEL);
		chk(o_program_no, 16'h0123);
		rdc(RDIO_A_PROG, 32'h0123);
		i_numeric_value_field <= 16'h0050;
		pl(E_OSEL);
		chk(o_override, 16'h0050);
		i_plc.slot_pulse(0);
		i_plc.slot_pulse(31);
		w(3);
		chk(o_slot_operating, 32'h80000001);
		i_slot_halt_in <= 32'h80000000;
		w(3);
		chk(o_slot_waiting, 32'h80000000);
		chk(o_slot_operating, 32'h00000001);
		i_slot_halt_in <= 32'h0;
		pl(E_PRST);
		bus(1'b1, RDIO_A_EVENT, 32'h4);
		w(3);
		chk(o_slot_operating | o_slot_waiting, 32'h0);
		pl(E_EVA);
		chk(o_evasion_active, 1'b1);
		bus(1'b1, RDIO_A_EVENT, 32'h10);
		w(3);
		chk(o_evasion_active, 1'b0);
		done("slots and selection");
		bus(1'b1, RDIO_A_EVENT, 32'h1);
		w(3);
		chk(o_error, 1'b1);
		pl(E_START);
		chk(o_operating, 1'b0);
		pl(E_FCLR);
		chk(o_error, 1'b0);
		i_plc.emergency(1'b1);
		w(4);
		chk(o_emergency_stop_flag, 1'b1);
		chk(o_servo_on, 1'b0);
		i_plc.emergency(1'b0);
		bus(1'b1, RDIO_A_GPO, 32'hdeadbeef);
		w(2);
		chk(o_gp_out, 32'hdeadbeef);
		rdc(RDIO_A_GPO, 32'hdeadbeef);
		pl(E_GCLR);
		chk(o_gp_out, 32'h0);
		done("faults and outputs");
		end_of_test();
	end
endmodule
